// file: bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic       clk = 1'b0, txd, lkd, tx_load, wmode, lk, arm, recal, sleep, sysr, cpol, cpend;
    logic       sync, busy, rst = 1'b1, rx_v = 1'b0, burst = 1'b0, wake = 1'b1;
    logic       hold = 1'b0, cstrap = 1'b0, calb = 1'b0;
    logic [7:0] rx_b = 8'h00, tx_byte, last;
    logic [1:0] strap = 2'h1, msel, mpend;
    int         n_errors = 0;
    int         n_tests = 0;
    int         n_rep = 0, n_rc = 0, n_lk = 0, n_sr = 0, n_ar = 0;
    // id values are arbitrary
    tsc_supervisor #(.TWIN_CYC(50), .TRST_CYC(20), .TSTUCK_CYC(100),
                     .VERSION(8'h3a), .SIGNATURE(8'h7e)) dut (
        .i_clk_sys(clk), .i_rst(rst), .i_rx_valid(rx_v), .i_rx_byte(rx_b),
        .i_tx_done(txd), .i_lock_done(lkd), .i_burst_active(burst), .i_cal_busy(calb),
        .i_wake_sense_pin(wake), .i_mclk_strap(strap), .i_clamp_strap(cstrap),
        .o_tx_load(tx_load), .o_tx_byte(tx_byte), .o_write_mode(wmode), .o_lock_start(lk),
        .o_bound_arm(arm), .o_recal_start(recal), .o_sleep(sleep), .o_sys_reset(sysr),
        .o_mclk_sel(msel), .o_mclk_pend(mpend), .o_clamp_pol(cpol), .o_clamp_pend(cpend),
        .o_sync_out(sync), .o_busy(busy));
    tsc_host_model host (.i_clk_sys(clk), .i_tx_load(tx_load), .i_lock_start(lk),
        .i_hold_ss(hold), .o_tx_done(txd), .o_lock_done(lkd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tx_load) begin
            n_rep <= n_rep + 1;
            last  <= tx_byte;
        end
        n_rc <= n_rc + recal;
        n_lk <= n_lk + lk;
        n_sr <= n_sr + sysr;
        n_ar <= n_ar + arm;
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        @(negedge clk) rx_v = 1'b1;
        rx_b = b;
        @(negedge clk) rx_v = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic xfer(input logic [7:0] b, nexp, exp);
        int n0;
        n0 = n_rep;
        send(b);
        check("reply count", 8'(n_rep - n0), nexp);
        if (nexp != 0) check("reply byte", last, exp);
    endtask
    task automatic wait_sr(input int lim);
        int n0;
        n0 = n_sr;
        for (int i = 0; i < lim && n_sr == n0; i++) @(negedge clk);
        check("reset request", 8'(n_sr - n0), 8'h01);
        if (n_sr == n0) results();
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        do_reset();
        check("rate in use", {6'h0, msel}, 8'h01);
        xfer(8'h62, 0, 0);
        xfer(8'h4c, 0, 0);
        xfer(8'h70, 1, 8'h70);
        xfer(8'h62, 1, 8'h62);
        calb = 1'b1;
        xfer(8'h62, 1, 8'h62);
        calb = 1'b0;
        check("recal starts", 8'(n_rc), 8'h02);
        check("bound arms", 8'(n_ar), 8'h03);
        xfer(8'h6c, 1, 8'h62);
        xfer(8'h6c, 1, 8'h6c);
        xfer(8'h56, 1, 8'h3a);
        xfer(8'h57, 1, 8'h7e);
        for (int r = 0; r < 5; r++) begin
            send(8'h11);
            xfer(8'(r), 8'(r < 4), 8'h11);
        end
        check("rate in use", {6'h0, msel}, 8'h01);
        check("rate written", {6'h0, mpend}, 8'h03);
        send(8'h13);
        xfer(8'h01, 1, 8'h13);
        check("clamp", {6'h0, cpend, cpol}, 8'h02);
        for (int s = 1; s >= 0; s--) begin
            send(8'h12);
            xfer(8'(s), 1, 8'h12);
            burst = 1'b1;
            #1 check("sync", {7'h0, sync}, 8'(s));
            burst = 1'b0;
            #1 check("sync idle", {7'h0, sync}, 8'h00);
        end
        xfer(8'h67, 1, 8'h67);
        xfer(8'h11, 1, 8'h03);
        xfer(8'h70, 1, 8'h70);
        send(8'h4c);
        xfer(8'h05, 0, 0);
        send(8'h4c);
        check("busy", {7'h0, busy}, 8'h01);
        repeat (60) @(negedge clk);
        check("busy", {7'h0, busy}, 8'h00);
        send(8'h00);
        check("lock starts", 8'(n_lk), 8'h00);
        send(8'h4c);
        xfer(8'h00, 0, 0);
        check("lock starts", 8'(n_lk), 8'h01);
        repeat (12) @(negedge clk);
        check("lock echo", last, 8'h4c);
        send(8'h72);
        xfer(8'h33, 0, 0);
        send(8'h72);
        xfer(8'h00, 1, 8'h72);
        wait_sr(60);
        strap = 2'h3;
        cstrap = 1'b1;
        do_reset();
        check("rate in use", {6'h0, msel}, 8'h03);
        check("clamp in use", {7'h0, cpol}, 8'h01);
        xfer(8'h70, 1, 8'h70);
        hold = 1'b1;
        send(8'h72);
        xfer(8'h00, 1, 8'h72);
        wait_sr(150);
        hold = 1'b0;
        do_reset();
        xfer(8'h70, 1, 8'h70);
        send(8'h5a);
        xfer(8'h01, 0, 0);
        send(8'h5a);
        xfer(8'h00, 1, 8'h5a);
        repeat (12) @(negedge clk);
        check("asleep", {7'h0, sleep}, 8'h01);
        xfer(8'h56, 0, 0);
        wake = 1'b0;
        repeat (100) @(negedge clk);
        wake = 1'b1;
        repeat (10) @(negedge clk);
        check("asleep", {7'h0, sleep}, 8'h01);
        wake = 1'b0;
        repeat (220) @(negedge clk);
        wake = 1'b1;
        check("asleep", {7'h0, sleep}, 8'h00);
        check("wake echo", last, 8'h5a);
        check("direction", {7'h0, wmode}, 8'h00);
        xfer(8'h70, 1, 8'h70);
        hold = 1'b1;
        send(8'h5a);
        xfer(8'h00, 1, 8'h5a);
        wait_sr(150);
        results();
    end
endmodule // testbench
`default_nettype wire

// file: bench/tsc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tsc_checker #(
    parameter int         TRST_CYC = 20,
    parameter logic [7:0] VERSION  = 8'h15
) (
    input wire       i_clk_sys,        // clock
    input wire       i_rst,            // reset
    input wire       i_rx_valid,       // byte strobe
    input wire [7:0] i_rx_byte,        // byte in
    input wire       i_tx_done,        // reply sent
    input wire       i_lock_done,      // storage done
    input wire       i_burst_active,   // burst
    input wire       i_wake_sense_pin, // wake pin
    input wire       o_tx_load,        // reply strobe
    input wire [7:0] o_tx_byte,        // reply
    input wire       o_write_mode,     // direction
    input wire       o_lock_start,     // lock
    input wire       o_sleep,          // asleep
    input wire       o_sys_reset,      // reset request
    input wire [1:0] o_mclk_sel,       // rate in use
    input wire       o_sync_out        // scope sync
);
    localparam int TR_LO = TRST_CYC - 1;
    localparam int TR_HI = TRST_CYC + 1;
    logic rst_echo;
    wire  idle = i_rx_valid && !o_sleep;
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rst_echo <= 1'b0;
        end else if (o_tx_load) begin
            rst_echo <= (o_tx_byte == 8'h72);
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    mode_put_a: assert property (
        idle && i_rx_byte == 8'h70 && !o_write_mode |=> o_write_mode && o_tx_byte == 8'h70)
        else $error("put byte not honoured");
    put_refuse_a: assert property (
        idle && !o_write_mode && i_rx_byte == 8'h4c |=> !o_tx_load)
        else $error("put-only byte answered in read mode");
    version_a: assert property (
        idle && i_rx_byte == 8'h56 |=> o_tx_load && o_tx_byte == VERSION)
        else $error("version reply wrong");
    lock_echo_a: assert property (
        i_lock_done |=> o_tx_load && o_tx_byte == 8'h4c)
        else $error("lock echo missing");
    lock_wait_a: assert property (
        o_lock_start |=> !o_tx_load [*4])
        else $error("lock echo before storage done");
    reset_delay_a: assert property (
        rst_echo && i_tx_done |-> ##[TR_LO:TR_HI] o_sys_reset)
        else $error("reset not requested in time");
    mclk_hold_a: assert property (
        !$past(i_rst, 2) |-> $stable(o_mclk_sel))
        else $error("clock rate changed without reset");
    wake_echo_a: assert property (
        $fell(o_sleep) |-> ##[0:1] (o_tx_load && o_tx_byte == 8'h5a))
        else $error("wake echo missing");
    wake_read_a: assert property (
        $fell(o_sleep) |-> !o_write_mode)
        else $error("woke in write mode");
    wake_min_a: assert property (
        o_sleep && i_wake_sense_pin [*4] |=> o_sleep)
        else $error("woke with pin high");
    sync_low_a: assert property (
        o_sync_out |-> i_burst_active)
        else $error("sync high outside burst");
    cover property (o_lock_start);
    cover property (rst_echo && i_tx_done);
    cover property ($fell(o_sleep));
endmodule // tsc_checker
bind tsc_supervisor tsc_checker #(.TRST_CYC(TRST_CYC), .VERSION(VERSION)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rx_valid(i_rx_valid), .i_rx_byte(i_rx_byte),
    .i_tx_done(i_tx_done), .i_lock_done(i_lock_done), .i_burst_active(i_burst_active),
    .i_wake_sense_pin(i_wake_sense_pin), .o_tx_load(o_tx_load), .o_tx_byte(o_tx_byte),
    .o_write_mode(o_write_mode), .o_lock_start(o_lock_start), .o_sleep(o_sleep),
    .o_sys_reset(o_sys_reset), .o_mclk_sel(o_mclk_sel), .o_sync_out(o_sync_out));
`default_nettype wire

// file: bench/tsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tsc_host_model (
    input  wire logic i_clk_sys,    // system clock
    input  wire logic i_tx_load,    // reply loaded
    input  wire logic i_lock_start, // storage write begins
    input  wire logic i_hold_ss,    // host keeps select, reply stuck
    output var  logic o_tx_done,    // reply shifted out
    output var  logic o_lock_done   // storage write finished
);
    int tx_cnt = 0;
    int lk_cnt = 0;
    initial o_tx_done = 1'b0;
    initial o_lock_done = 1'b0;
    // a held select never lets the reply out, so done stays low
    always @(negedge i_clk_sys) begin
        o_tx_done   <= (tx_cnt == 1) && !i_hold_ss;
        o_lock_done <= (lk_cnt == 1);
        tx_cnt      <= i_tx_load ? 8 : (tx_cnt > 0 ? tx_cnt - 1 : 0);
        lk_cnt      <= i_lock_start ? 6 : (lk_cnt > 0 ? lk_cnt - 1 : 0);
    end
endmodule // tsc_host_model
`default_nettype wire

// file: rtl/tsc_consts.vh
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH
// command bytes
`define TSC_CMD_PUT       8'h70
`define TSC_CMD_GET       8'h67
`define TSC_CMD_LOCK      8'h4c
`define TSC_CMD_RECAL     8'h62
`define TSC_CMD_LAST      8'h6c
`define TSC_CMD_RESET     8'h72
`define TSC_CMD_VERSION   8'h56
`define TSC_CMD_SIGN      8'h57
`define TSC_CMD_SLEEP     8'h5a
`define TSC_CMD_MCLK      8'h11
`define TSC_CMD_SYNC      8'h12
`define TSC_CMD_CLAMP     8'h13
`define TSC_NULL          8'h00
// timing, in their own units, at 20 MHz (50 ns)
`define TSC_CLK_HZ        20000000
`define TSC_TWIN_MS       100
`define TSC_TRST_MS       16
`define TSC_TSTUCK_MS     2000
`define TSC_TWAKE_US      10
`define TSC_TWIN_CYC      ((`TSC_TWIN_MS * (`TSC_CLK_HZ / 1000)))
`define TSC_TRST_CYC      ((`TSC_TRST_MS * (`TSC_CLK_HZ / 1000)))
`define TSC_TSTUCK_CYC    ((`TSC_TSTUCK_MS * (`TSC_CLK_HZ / 1000)))
`define TSC_TWAKE_CYC     ((`TSC_TWAKE_US * (`TSC_CLK_HZ / 1000000)) + 1)
// reset values
`define TSC_MCLK_RST      2'h0
`define TSC_SYNC_RST      1'b0
`define TSC_CLAMP_RST     1'b0
`endif

// file: rtl/tsc_supervisor.v
`timescale 1ns/1ns
`include "tsc_consts.vh"
`default_nettype none
module tsc_supervisor #(
    parameter TWIN_CYC   = `TSC_TWIN_CYC,
    parameter TRST_CYC   = `TSC_TRST_CYC,
    parameter TSTUCK_CYC = `TSC_TSTUCK_CYC,
    parameter [7:0] VERSION   = 8'h15,  // arbitrary value
    parameter [7:0] SIGNATURE = 8'h5c   // arbitrary value
) (
    input  wire       i_clk_sys,        // system clock 20 MHz
    input  wire       i_rst,            // async reset, active high
    input  wire       i_rx_valid,       // one-cycle pulse: command byte received
    input  wire [7:0] i_rx_byte,        // received byte
    input  wire       i_tx_done,        // pulse: reply byte shifted out to host
    input  wire       i_lock_done,      // pulse: storage write finished
    input  wire       i_burst_active,   // acquisition burst of scoped keys
    input  wire       i_cal_busy,       // scoped keys calibrating
    input  wire       i_wake_sense_pin, // wake pin, async, low wakes
    input  wire [1:0] i_mclk_strap,     // mclk rate kept in storage
    input  wire       i_clamp_strap,    // clamp polarity kept in storage
    output reg        o_tx_load,        // pulse: load o_tx_byte for next transfer
    output reg  [7:0] o_tx_byte,        // reply byte
    output reg        o_write_mode,     // direction flag, 1 = write
    output reg        o_lock_start,     // pulse: store all keys' reference data
    output reg        o_bound_arm,      // pulse: boundary checks may begin
    output reg        o_recal_start,    // pulse: (re)start scoped calibration
    output reg        o_sleep,          // device asleep
    output reg        o_sys_reset,      // pulse: full device reset request
    output reg  [1:0] o_mclk_sel,       // master clock rate in effect
    output reg  [1:0] o_mclk_pend,      // master clock rate written
    output reg        o_clamp_pol,      // clamp polarity in effect
    output reg        o_clamp_pend,     // clamp polarity written
    output wire       o_sync_out,       // scope sync, rests low
    output reg        o_busy            // waiting for second byte, storage, reset or wake
);
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_ARG   = 7'h02;
    localparam [6:0] S_LOCKW = 7'h04;
    localparam [6:0] S_RSTE  = 7'h08;
    localparam [6:0] S_RSTW  = 7'h10;
    localparam [6:0] S_SLPE  = 7'h20;
    localparam [6:0] S_SLP   = 7'h40;

    reg  [6:0]  state;
    reg  [7:0]  pend_cmd;
    reg  [7:0]  last_cmd;
    reg         last_rep;
    reg  [31:0] tmr;
    reg         sync_en;
    reg  [7:0]  wake_cnt;
    reg         wk_m;
    reg         wk_s;
    reg         boot;

    // rising burst edges not needed: pulse follows burst while enabled
    assign o_sync_out = sync_en & i_burst_active;

    function is_arg_cmd;
        input [7:0] b;
        begin
            is_arg_cmd = (b == `TSC_CMD_LOCK) || (b == `TSC_CMD_RESET) ||
                         (b == `TSC_CMD_SLEEP) || (b == `TSC_CMD_MCLK) ||
                         (b == `TSC_CMD_SYNC) || (b == `TSC_CMD_CLAMP);
        end
    endfunction

    // wake pin is asynchronous: two flops before any logic
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wk_m <= 1'b1;
            wk_s <= 1'b1;
        end else begin
            wk_m <= i_wake_sense_pin;
            wk_s <= wk_m;
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state         <= S_IDLE;
            pend_cmd      <= 8'h00;
            last_cmd      <= 8'h00;
            last_rep      <= 1'b0;
            tmr           <= 32'h0;
            sync_en       <= `TSC_SYNC_RST;
            wake_cnt      <= 8'h00;
            boot          <= 1'b1;
            o_tx_load     <= 1'b0;
            o_tx_byte     <= 8'h00;
            o_write_mode  <= 1'b0;
            o_lock_start  <= 1'b0;
            o_bound_arm   <= 1'b0;
            o_recal_start <= 1'b0;
            o_sleep       <= 1'b0;
            o_sys_reset   <= 1'b0;
            o_mclk_sel    <= `TSC_MCLK_RST;
            o_mclk_pend   <= `TSC_MCLK_RST;
            o_clamp_pol   <= `TSC_CLAMP_RST;
            o_clamp_pend  <= `TSC_CLAMP_RST;
            o_busy        <= 1'b0;
        end else begin
            o_tx_load     <= 1'b0;
            o_lock_start  <= 1'b0;
            o_bound_arm   <= 1'b0;
            o_recal_start <= 1'b0;
            o_sys_reset   <= 1'b0;
            boot          <= 1'b0;
            // stored settings take effect at (re)start only
            if (boot) begin
                o_mclk_sel   <= i_mclk_strap;
                o_mclk_pend  <= i_mclk_strap;
                o_clamp_pol  <= i_clamp_strap;
                o_clamp_pend <= i_clamp_strap;
                o_bound_arm  <= 1'b1;
            end
            if (i_rx_valid && state != S_SLP) begin
                if (i_rx_byte == `TSC_CMD_LAST) begin
                    last_rep <= 1'b1;
                end else begin
                    last_rep <= 1'b0;
                    last_cmd <= i_rx_byte;         // erroneous bytes too
                end
            end
            case (state)
            S_IDLE: begin
                o_busy <= 1'b0;
                if (i_rx_valid) begin
                    o_tx_load <= 1'b1;
                    o_tx_byte <= i_rx_byte;
                    case (i_rx_byte)
                    `TSC_CMD_PUT: o_write_mode <= 1'b1;
                    `TSC_CMD_GET: o_write_mode <= 1'b0;
                    `TSC_CMD_LAST: o_tx_byte <= last_rep ? `TSC_CMD_LAST : last_cmd;
                    `TSC_CMD_VERSION: o_tx_byte <= VERSION;
                    `TSC_CMD_SIGN: o_tx_byte <= SIGNATURE;
                    `TSC_CMD_RECAL: begin
                        // restart even if already calibrating
                        if (o_write_mode) begin
                            o_recal_start <= 1'b1;
                            o_bound_arm   <= 1'b1;
                        end else begin
                            o_tx_load <= 1'b0;
                        end
                    end
                    `TSC_CMD_SYNC: begin
                        // get form returns setting; put form needs operand
                        if (!o_write_mode) o_tx_byte <= {7'h00, sync_en};
                    end
                    `TSC_CMD_MCLK: begin
                        if (!o_write_mode) o_tx_byte <= {6'h00, o_mclk_pend};
                    end
                    `TSC_CMD_CLAMP: begin
                        if (!o_write_mode) o_tx_byte <= {7'h00, o_clamp_pend};
                    end
                    default: ;
                    endcase
                    if (is_arg_cmd(i_rx_byte) && o_write_mode) begin
                        o_tx_load <= 1'b0;
                        pend_cmd  <= i_rx_byte;
                        tmr       <= 32'h0;
                        state     <= S_ARG;
                        o_busy    <= 1'b1;
                    end else if (is_arg_cmd(i_rx_byte) && i_rx_byte != `TSC_CMD_SYNC &&
                                 i_rx_byte != `TSC_CMD_MCLK && i_rx_byte != `TSC_CMD_CLAMP) begin
                        o_tx_load <= 1'b0;         // put-only in read mode: ignored
                    end
                end
            end
            S_ARG: begin
                tmr <= tmr + 32'h1;
                if (tmr >= TWIN_CYC - 1) begin
                    state <= S_IDLE;
                end else if (i_rx_valid) begin
                    state <= S_IDLE;
                    case (pend_cmd)
                    `TSC_CMD_LOCK: if (i_rx_byte == `TSC_NULL) begin
                        o_lock_start <= 1'b1;
                        state        <= S_LOCKW;
                    end
                    `TSC_CMD_RESET: if (i_rx_byte == `TSC_NULL) begin
                        o_tx_load <= 1'b1;
                        o_tx_byte <= `TSC_CMD_RESET;
                        tmr       <= 32'h0;
                        state     <= S_RSTE;
                    end
                    `TSC_CMD_SLEEP: if (i_rx_byte == `TSC_NULL) begin
                        o_tx_load <= 1'b1;
                        o_tx_byte <= `TSC_CMD_SLEEP;
                        tmr       <= 32'h0;
                        state     <= S_SLPE;
                    end
                    `TSC_CMD_MCLK: if (i_rx_byte[7:2] == 6'h00) begin
                        o_mclk_pend <= i_rx_byte[1:0];
                        o_tx_load   <= 1'b1;
                        o_tx_byte   <= `TSC_CMD_MCLK;
                    end
                    `TSC_CMD_SYNC: if (i_rx_byte[7:1] == 7'h00) begin
                        sync_en   <= i_rx_byte[0];
                        o_tx_load <= 1'b1;
                        o_tx_byte <= `TSC_CMD_SYNC;
                    end
                    `TSC_CMD_CLAMP: if (i_rx_byte[7:1] == 7'h00) begin
                        o_clamp_pend <= i_rx_byte[0];
                        o_tx_load    <= 1'b1;
                        o_tx_byte    <= `TSC_CMD_CLAMP;
                    end
                    default: ;
                    endcase
                end
            end
            S_LOCKW: if (i_lock_done) begin
                o_tx_load <= 1'b1;
                o_tx_byte <= `TSC_CMD_LOCK;
                state     <= S_IDLE;
            end
            S_RSTE: begin
                tmr <= tmr + 32'h1;
                if (i_tx_done) begin
                    tmr   <= 32'h0;
                    state <= S_RSTW;
                end else if (tmr >= TSTUCK_CYC - 1) begin
                    o_sys_reset <= 1'b1;
                    state       <= S_IDLE;
                end
            end
            S_RSTW: begin
                tmr <= tmr + 32'h1;
                if (tmr >= TRST_CYC - 1) begin
                    o_sys_reset <= 1'b1;
                    state       <= S_IDLE;
                end
            end
            S_SLPE: begin
                tmr <= tmr + 32'h1;
                if (i_tx_done) begin
                    o_sleep  <= 1'b1;
                    wake_cnt <= 8'h00;
                    state    <= S_SLP;
                end else if (tmr >= TSTUCK_CYC - 1) begin
                    o_sys_reset <= 1'b1;
                    state       <= S_IDLE;
                end
            end
            S_SLP: begin
                // high pin restarts the low-time count
                wake_cnt <= wk_s ? 8'h00 : wake_cnt + 8'h01;
                if (!wk_s && wake_cnt >= (`TSC_TWAKE_CYC) - 1) begin
                    o_sleep      <= 1'b0;
                    o_write_mode <= 1'b0;
                    o_tx_load    <= 1'b1;
                    o_tx_byte    <= `TSC_CMD_SLEEP;
                    state        <= S_IDLE;
                end
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule // tsc_supervisor
`default_nettype wire
